// ---- sas_pkg.sv ----
// Shared constants of the serial converter sequencer: widths, channel codes,
// test levels, edge numbers of the transfer and host timing.
// Assumes both ends and the testbench import it.
package sas_pkg;

   localparam int          RES_W        = 10;
   localparam int          ADDR_W       = 4;
   localparam int          N_EXT        = 11;
   localparam int          CNT_W        = 4;
   localparam int          NCLK_W       = 5;
   localparam int          TIMER_W      = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Channel codes and the ideal levels of the internal test inputs.
   localparam logic [3:0]  CODE_LAST_EXT = 4'hA;
   localparam logic [3:0]  CODE_MID      = 4'hB;
   localparam logic [3:0]  CODE_LO       = 4'hC;
   localparam logic [3:0]  CODE_HI       = 4'hD;
   localparam logic [9:0]  LVL_MID       = 10'h200;
   localparam logic [9:0]  LVL_LO        = 10'h000;
   localparam logic [9:0]  LVL_HI        = 10'h3FF;

   ////////////////////////////////////////////////////////////////////////////
   // Edge numbers within one transfer, counted from one.
   localparam int          ADDR_RISES   = 4;
   localparam int          SAMPLE_FALL  = 4;
   localparam int          HOLD_FALL    = 10;
   localparam int          CLOCKS_MIN   = 11;
   localparam int          CLOCKS_MAX   = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Host timing at the system clock rate.
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          T_SU_CS_NS     = 1425;
   localparam int          T_ELEVENTH_NS  = 9500;
   localparam int          SU_CS_CYC      = (T_SU_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          ELEVENTH_CYC   = T_ELEVENTH_NS / CLK_PERIOD_NS;

endpackage

// ---- sas_link_if.sv ----
// Four-wire serial link plus the conversion-done pin between host and converter.
// Assumes the bench resolves the data line from dout_oe.
`timescale 1ns/1ps
interface sas_link_if;
   logic cs_n;
   logic io_clk;
   logic addr;
   logic dout;
   logic dout_oe;
   logic eoc;

   modport device (input cs_n, input io_clk, input addr, output dout, output dout_oe, output eoc);
   modport host   (output cs_n, output io_clk, output addr, input dout, input dout_oe, input eoc);
endinterface

// ---- sas_sar.sv ----
// Successive-approximation engine: one bit decision per step, MSB first.
// Assumes START and ABORT are single-cycle pulses on CLK.
`timescale 1ns/1ps
module sas_sar #(
   parameter int STEP_CYCLES = 8
) (
   input  wire logic                     CLK,
   input  wire logic                     RESET_N,
   input  wire logic                     START,
   input  wire logic                     ABORT,
   input  wire logic [sas_pkg::RES_W-1:0] SAMPLE,
   output logic      [sas_pkg::RES_W-1:0] RESULT,
   output logic                          DONE,
   output logic                          BUSY
);
   import sas_pkg::*;

   localparam int STEP_W = $clog2(STEP_CYCLES + 1);

   logic              busy_q;
   logic              done_q;
   logic [STEP_W-1:0] step_q;
   logic [CNT_W-1:0]  bit_q;
   logic [RES_W-1:0]  acc_q;
   logic [RES_W-1:0]  res_q;
   logic [RES_W-1:0]  trial;
   logic [RES_W-1:0]  decided;
   logic              step_end;

   assign trial    = acc_q | (RES_W'(1) << bit_q);
   assign decided  = (trial <= SAMPLE) ? trial : acc_q;
   assign step_end = busy_q && (step_q == STEP_W'(STEP_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         step_q <= '0;
         bit_q  <= '0;
         acc_q  <= '0;
         res_q  <= '0;
      end else begin
         done_q <= 1'b0;
         if (ABORT) begin
            busy_q <= 1'b0;
         end else if (START) begin
            busy_q <= 1'b1;
            acc_q  <= '0;
            step_q <= '0;
            bit_q  <= CNT_W'(RES_W - 1);
         end else if (step_end) begin
            step_q <= '0;
            acc_q  <= decided;
            if (bit_q == '0) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               res_q  <= decided;
            end else begin
               bit_q <= bit_q - CNT_W'(1);
            end
         end else if (busy_q) begin
            step_q <= step_q + STEP_W'(1);
         end
      end
   end

   assign RESULT = res_q;
   assign DONE   = done_q;
   assign BUSY   = busy_q;

endmodule // sas_sar

// ---- sas_device.sv ----
// Converter end of the serial link: transfer counters on the shift clock,
// channel selection, sample hold and conversion control on the system clock.
// Assumes the host keeps the clock counts of the chosen mode and that the
// shift clock idles low with select high between toggled transfers.
`timescale 1ns/1ps

// Summary of operation
// - Toggled select: host raises select, 11-16 clocks.
// - Output leaves high impedance while select low.
// - Select high disables clock and address inputs.
// - Host never gives more than sixteen clocks.
// - Held select: exactly sixteen clocks every transfer.
// - Fast held: release output at done rising.
// - Slow: eleventh rise before conversion completes.
// - Eleventh rise within 9.5 us of tenth fall.
// - Slow held: release output at sixteenth fall.
// - Channel code captured MSB first, four rises.
// - Code selects one of fourteen sources.
// - Codes 0 to 10 pick external inputs.
// - Codes B, C, D pick mid, low, high.
// - Sample from fourth fall, hold at tenth.
// - Ten bit decisions, MSB first, keep if not above.
// - Select fall starts cycle, aborts ongoing conversion.
// - Host avoids select fall near conversion end.
// - Remaining nine bits on next nine falls.
// - Done goes low at tenth fall, high when ready.
// - Output forced low from tenth fall.
module sas_device #(
   parameter int STEP_CYCLES = 8
) (
   input  wire logic                     CLK,
   input  wire logic                     RESET_N,
   sas_link_if.device                    LINK,
   input  wire logic [sas_pkg::RES_W-1:0] ANALOG_INPUT [sas_pkg::N_EXT],
   output logic      [sas_pkg::RES_W-1:0] LAST_RESULT,
   output logic                          BUSY
);
   import sas_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Shift-clock domain. Select high clears the transfer state at once, so the
   // clock and address pins are ignored without waiting for any edge.

   logic              io_rst_n;
   logic [CNT_W-1:0]  rise_cnt_q;
   logic [CNT_W-1:0]  fall_cnt_q;
   logic [ADDR_W-1:0] code_q;
   logic              sample_q;
   logic              wait_q;
   logic              start_tgl_q;
   logic              eoc_io1_q;
   logic              eoc_io2_q;
   logic              addr_phase;
   logic              sample_fall;
   logic              hold_fall;
   logic              last_fall;

   assign io_rst_n    = RESET_N & ~LINK.cs_n;
   assign addr_phase  = rise_cnt_q < CNT_W'(ADDR_RISES);
   assign sample_fall = fall_cnt_q == CNT_W'(SAMPLE_FALL - 1);
   assign hold_fall   = fall_cnt_q == CNT_W'(HOLD_FALL - 1);
   assign last_fall   = fall_cnt_q == CNT_W'(CLOCKS_MAX - 1);

   // Counters wrap after sixteen edges, which starts the next held transfer.
   always_ff @(posedge LINK.io_clk or negedge io_rst_n) begin
      if (!io_rst_n) begin
         rise_cnt_q <= '0;
         code_q     <= '0;
      end else begin
         rise_cnt_q <= rise_cnt_q + CNT_W'(1);
         if (addr_phase) begin
            code_q <= {code_q[ADDR_W-2:0], LINK.addr};
         end
      end
   end

   always_ff @(negedge LINK.io_clk or negedge io_rst_n) begin
      if (!io_rst_n) begin
         fall_cnt_q <= '0;
         sample_q   <= 1'b0;
         wait_q     <= 1'b0;
      end else begin
         fall_cnt_q <= fall_cnt_q + CNT_W'(1);
         if (sample_fall) begin
            sample_q <= 1'b1;
         end else if (hold_fall) begin
            sample_q <= 1'b0;
         end
         // A sixteenth fall before done means fast held mode: stay low
         // until done rises; after done it is slow held mode.
         wait_q <= last_fall & ~eoc_io2_q;
      end
   end

   // The start toggle must survive select going high, or the system clock
   // side would see a false start; only the chip reset clears it.
   always_ff @(negedge LINK.io_clk or negedge RESET_N) begin
      if (!RESET_N) begin
         start_tgl_q <= 1'b0;
         eoc_io1_q   <= 1'b1;
         eoc_io2_q   <= 1'b1;
      end else begin
         eoc_io1_q <= LINK.eoc;
         eoc_io2_q <= eoc_io1_q;
         if (hold_fall) begin
            start_tgl_q <= ~start_tgl_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output. The release on done rising is a combinational path,
   // since the shift clock is stopped at that moment.

   logic              shifting;
   logic              held_low;
   logic [CNT_W-1:0]  out_idx;
   logic [CNT_W-1:0]  bit_sel;
   logic [RES_W-1:0]  result_q;
   logic              eoc_q;

   assign shifting     = fall_cnt_q < CNT_W'(HOLD_FALL);
   assign held_low     = wait_q & ~eoc_q;
   assign out_idx      = CNT_W'(RES_W - 1) - fall_cnt_q;
   assign bit_sel      = shifting ? out_idx : '0;
   assign LINK.dout    = shifting & ~held_low & result_q[bit_sel];
   assign LINK.dout_oe = ~LINK.cs_n;
   assign LINK.eoc     = eoc_q;

   ////////////////////////////////////////////////////////////////////////////
   // System-clock domain: crossings, channel selection and conversion.

   logic [2:0]        start_s_q;
   logic [1:0]        samp_s_q;
   logic [2:0]        cs_s_q;
   logic              start_conv;
   logic              cs_fall;
   logic              code_ext;
   logic [RES_W-1:0]  chan_level;
   logic [RES_W-1:0]  hold_level_q;
   logic [RES_W-1:0]  sar_result;
   logic              sar_done;
   logic              sar_busy;

   assign start_conv = start_s_q[2] ^ start_s_q[1];
   assign cs_fall    = cs_s_q[2] & ~cs_s_q[1];
   assign code_ext   = code_q <= CODE_LAST_EXT;

   // Unused codes above the test levels convert the lower reference.
   assign chan_level = code_ext ? ANALOG_INPUT[code_q] :
                       (code_q == CODE_MID) ? LVL_MID :
                       (code_q == CODE_LO)  ? LVL_LO :
                       (code_q == CODE_HI)  ? LVL_HI : LVL_LO;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         start_s_q <= '0;
         samp_s_q  <= '0;
         cs_s_q    <= '1;
      end else begin
         start_s_q <= {start_s_q[1:0], start_tgl_q};
         samp_s_q  <= {samp_s_q[0], sample_q};
         cs_s_q    <= {cs_s_q[1:0], LINK.cs_n};
      end
   end

   // The code is stable from the fourth rise, before the sampling level
   // reaches this side, so it is read only while that level is high.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hold_level_q <= '0;
      end else if (samp_s_q[1]) begin
         hold_level_q <= chan_level;
      end
   end

   sas_sar #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_sar (
      .CLK     (CLK),
      .RESET_N (RESET_N),
      .START   (start_conv),
      .ABORT   (cs_fall),
      .SAMPLE  (hold_level_q),
      .RESULT  (sar_result),
      .DONE    (sar_done),
      .BUSY    (sar_busy)
   );

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         eoc_q    <= 1'b1;
         result_q <= '0;
      end else begin
         if (cs_fall) begin
            eoc_q <= 1'b1;
         end else if (start_conv) begin
            eoc_q <= 1'b0;
         end else if (sar_done) begin
            eoc_q <= 1'b1;
         end
         if (sar_done && !cs_fall) begin
            result_q <= sar_result;
         end
      end
   end

   assign LAST_RESULT = result_q;
   assign BUSY        = sar_busy;

endmodule // sas_device

// ---- sas_host.sv ----
// Host end: drives select, the divided shift clock and the address, and
// collects the ten result bits of the previous conversion.
// Assumes the converter end on the same link interface.
`timescale 1ns/1ps
module sas_host #(
   parameter int HALF_CYCLES = 6
) (
   input  wire logic                      CLK,
   input  wire logic                      RESET_N,
   sas_link_if.host                       LINK,
   input  wire logic                      START,
   input  wire logic [sas_pkg::ADDR_W-1:0] CHANNEL,
   input  wire logic [sas_pkg::NCLK_W-1:0] NUM_CLOCKS,
   input  wire logic                      HOLD_CS,
   output logic                           READY,
   output logic      [sas_pkg::RES_W-1:0]  RESULT,
   output logic                           RESULT_VALID
);
   import sas_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} sas_hstate_t;

   sas_hstate_t        state_q;
   logic [TIMER_W-1:0] cnt_q;
   logic [NCLK_W-1:0]  clk_n_q;
   logic [NCLK_W-1:0]  n_q;
   logic [ADDR_W-1:0]  chan_q;
   logic [RES_W-1:0]   shift_q;
   logic [RES_W-1:0]   res_q;
   logic               hold_q;
   logic               valid_q;
   logic               cs_n_q;
   logic               io_clk_q;
   logic               addr_q;
   logic [1:0]         dout_s_q;
   logic [1:0]         eoc_s_q;
   logic               half_end;
   logic               setup_end;
   logic               addr_bit;
   logic [NCLK_W-1:0]  n_clamped;
   logic [NCLK_W-1:0]  addr_pos;

   assign half_end  = cnt_q == TIMER_W'(HALF_CYCLES - 1);
   assign setup_end = cnt_q == TIMER_W'(SU_CS_CYC - 1);
   assign addr_pos  = NCLK_W'(ADDR_W - 1) - clk_n_q;
   assign addr_bit  = (clk_n_q < NCLK_W'(ADDR_W)) ? chan_q[addr_pos[1:0]] : 1'b0;
   assign n_clamped = HOLD_CS ? NCLK_W'(CLOCKS_MAX) :
                      (NUM_CLOCKS < NCLK_W'(CLOCKS_MIN)) ? NCLK_W'(CLOCKS_MIN) :
                      (NUM_CLOCKS > NCLK_W'(CLOCKS_MAX)) ? NCLK_W'(CLOCKS_MAX) : NUM_CLOCKS;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         dout_s_q <= '0;
         eoc_s_q  <= '0;
      end else begin
         dout_s_q <= {dout_s_q[0], LINK.dout};
         eoc_s_q  <= {eoc_s_q[0], LINK.eoc};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q  <= H_IDLE;
         cnt_q    <= '0;
         clk_n_q  <= '0;
         n_q      <= '0;
         chan_q   <= '0;
         shift_q  <= '0;
         res_q    <= '0;
         hold_q   <= 1'b0;
         valid_q  <= 1'b0;
         cs_n_q   <= 1'b1;
         io_clk_q <= 1'b0;
         addr_q   <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         case (state_q)
            H_IDLE: begin
               // Waiting for done keeps select from falling near the end
               // of a conversion.
               if (START && eoc_s_q[1]) begin
                  chan_q  <= CHANNEL;
                  n_q     <= n_clamped;
                  hold_q  <= HOLD_CS;
                  clk_n_q <= '0;
                  cnt_q   <= '0;
                  if (cs_n_q) begin
                     cs_n_q  <= 1'b0;
                     state_q <= H_SETUP;
                  end else begin
                     state_q <= H_LOW;
                  end
               end
            end
            H_SETUP: begin
               cnt_q <= cnt_q + TIMER_W'(1);
               if (setup_end) begin
                  cnt_q   <= '0;
                  state_q <= H_LOW;
               end
            end
            H_LOW: begin
               addr_q <= addr_bit;
               cnt_q  <= cnt_q + TIMER_W'(1);
               if (half_end) begin
                  cnt_q    <= '0;
                  io_clk_q <= 1'b1;
                  if (clk_n_q < NCLK_W'(RES_W)) begin
                     shift_q <= {shift_q[RES_W-2:0], dout_s_q[1]};
                  end
                  state_q <= H_HIGH;
               end
            end
            H_HIGH: begin
               cnt_q <= cnt_q + TIMER_W'(1);
               if (half_end) begin
                  cnt_q    <= '0;
                  io_clk_q <= 1'b0;
                  clk_n_q  <= clk_n_q + NCLK_W'(1);
                  state_q  <= (clk_n_q + NCLK_W'(1) == n_q) ? H_END : H_LOW;
               end
            end
            H_END: begin
               cnt_q <= cnt_q + TIMER_W'(1);
               if (!hold_q) begin
                  cs_n_q <= 1'b1;
               end
               if (half_end) begin
                  cnt_q   <= '0;
                  res_q   <= shift_q;
                  valid_q <= 1'b1;
                  state_q <= H_IDLE;
               end
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

   assign LINK.cs_n    = cs_n_q;
   assign LINK.io_clk  = io_clk_q;
   assign LINK.addr    = addr_q;
   assign READY        = (state_q == H_IDLE) && eoc_s_q[1];
   assign RESULT       = res_q;
   assign RESULT_VALID = valid_q;

endmodule // sas_host

// ---- sas_chk.sv ----
// Checker for the link between host end and converter end.
// Assumes the link signals as plain inputs and the system clock and reset.
`timescale 1ns/1ps
module sas_chk #(
   parameter int STEP_CYCLES = 8
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic addr,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic eoc
);
   localparam int CONV_MAX = 10 * STEP_CYCLES + 8;
   localparam int ELEV_MAX = sas_pkg::ELEVENTH_CYC;
   logic [3:0] fall_q;
   wire        at_tenth = (fall_q == 4'hA);

   ////////////////////////////////////////////////////////////////////////////
   // Falls of the shift clock within one frame; select high clears the count.
   always_ff @(negedge io_clk or posedge cs_n or negedge RESET_N) begin
      if (!RESET_N || cs_n) begin
         fall_q <= 4'h0;
      end else begin
         fall_q <= fall_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_oe_by_select;
      @(posedge CLK) disable iff (!RESET_N) dout_oe == !cs_n;
   endproperty
   a_oe_by_select: assert property (p_oe_by_select) else $error("output enable differs from select");
   property p_zero_after_tenth;
      @(posedge io_clk) disable iff (!RESET_N || cs_n) fall_q >= 4'hA |-> !dout;
   endproperty
   a_zero_after_tenth: assert property (p_zero_after_tenth) else $error("data not low after tenth fall");
   property p_done_drops;
      @(posedge CLK) disable iff (!RESET_N) $rose(at_tenth) |-> ##[1:5] !eoc;
   endproperty
   a_done_drops: assert property (p_done_drops) else $error("done did not drop after tenth fall");
   property p_done_only_tenth;
      @(posedge CLK) disable iff (!RESET_N) $fell(eoc) |-> at_tenth;
   endproperty
   a_done_only_tenth: assert property (p_done_only_tenth) else $error("done dropped off the tenth fall");
   property p_conv_min;
      @(posedge CLK) disable iff (!RESET_N) $fell(eoc) |=> !eoc [*8];
   endproperty
   a_conv_min: assert property (p_conv_min) else $error("conversion ended too soon");
   property p_conv_max;
      @(posedge CLK) disable iff (!RESET_N) $fell(eoc) |-> ##[1:CONV_MAX] eoc;
   endproperty
   a_conv_max: assert property (p_conv_max) else $error("conversion did not finish");
   property p_data_steady;
      @(posedge CLK) disable iff (!RESET_N)
         (!cs_n && !$past(cs_n) && eoc && $past(eoc) && !$fell(io_clk)) |-> $stable(dout);
   endproperty
   a_data_steady: assert property (p_data_steady) else $error("data moved off a clock fall");
   property p_idle_quiet;
      @(posedge CLK) disable iff (!RESET_N) (cs_n && $past(cs_n) && $past(eoc)) |-> eoc;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("conversion began without a frame");
   property p_eleventh_rise;
      @(posedge CLK) disable iff (!RESET_N) $rose(at_tenth) |-> ##[1:ELEV_MAX] io_clk;
   endproperty
   a_eleventh_rise: assert property (p_eleventh_rise) else $error("eleventh clock rise came too late");
endmodule // sas_chk

// ---- test_serial_adc_sequencer.sv ----
// Testbench: host end against converter end on one link, and a second
// converter end on a link driven directly by the bench in slow modes.
// Assumes the package, the link interface and both design ends.
`timescale 1ns/1ps
module test_serial_adc_sequencer;
   import sas_pkg::*;
   localparam int LIMIT = 40000;
   logic       CLK, RESET_N, START, HOLD_CS, valid, ready, busy_a, busy_b;
   logic [3:0] CHANNEL, prev;
   logic [4:0] NUM_CLOCKS;
   logic [9:0] res, last_a, last_b;
   logic [9:0] ana [N_EXT];
   logic [15:0] got;
   int         fail_count, n_compared, cyc;
   sas_link_if la ();
   sas_link_if lb ();

   sas_host #(.HALF_CYCLES(5)) i_sas_host (.CLK(CLK), .RESET_N(RESET_N), .LINK(la), .START(START),
      .CHANNEL(CHANNEL), .NUM_CLOCKS(NUM_CLOCKS), .HOLD_CS(HOLD_CS), .READY(ready), .RESULT(res),
      .RESULT_VALID(valid));
   sas_device #(.STEP_CYCLES(8)) i_sas_device (.CLK(CLK), .RESET_N(RESET_N), .LINK(la),
      .ANALOG_INPUT(ana), .LAST_RESULT(last_a), .BUSY(busy_a));
   // The slow end converts in about 13 cycles, well inside six shift periods.
   sas_device #(.STEP_CYCLES(1)) i_sas_device_b (.CLK(CLK), .RESET_N(RESET_N), .LINK(lb),
      .ANALOG_INPUT(ana), .LAST_RESULT(last_b), .BUSY(busy_b));
   sas_chk #(.STEP_CYCLES(8)) i_sas_chk (.CLK(CLK), .RESET_N(RESET_N), .cs_n(la.cs_n),
      .io_clk(la.io_clk), .addr(la.addr), .dout(la.dout), .dout_oe(la.dout_oe), .eoc(la.eoc));

   always #20 CLK = ~CLK;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] lvl(input logic [3:0] c);
      if (c <= CODE_LAST_EXT) return ana[c];
      if (c == CODE_MID) return LVL_MID;
      if (c == CODE_HI) return LVL_HI;
      return LVL_LO;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp_v);
      n_compared++;
      if (seen !== exp_v) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp_v);
      end
   endtask

   task automatic finish_test;
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic host_xfer(input logic [3:0] ch, input logic [4:0] n, input logic h, input logic [9:0] exp_v);
      for (int k = 0; k < 400 && ready !== 1'b1; k++) @(negedge CLK);
      CHANNEL = ch;
      NUM_CLOCKS = n;
      HOLD_CS = h;
      START = 1'b1;
      @(negedge CLK);
      START = 1'b0;
      for (int k = 0; k < 600 && valid !== 1'b1; k++) @(negedge CLK);
      check({6'h00, res}, {6'h00, exp_v});
   endtask

   // Frames on the bench link; a frame begun from idle waits out the select setup.
   task automatic b_xfer(input logic [3:0] ch, input int n, output logic [15:0] bits);
      bits = 16'h0000;
      if (lb.cs_n) begin
         lb.cs_n = 1'b0;
         #1500;
      end
      for (int i = 0; i < n; i++) begin
         lb.addr = (i < 4) ? ch[3 - i] : 1'b0;
         #62.5 lb.io_clk = 1'b1;
         bits[15 - i] = lb.dout;
         #62.5 lb.io_clk = 1'b0;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      CLK = 1'b0;
      RESET_N = 1'b0;
      START = 1'b0;
      HOLD_CS = 1'b0;
      CHANNEL = 4'h0;
      NUM_CLOCKS = 5'd11;
      lb.cs_n = 1'b1;
      lb.io_clk = 1'b0;
      lb.addr = 1'b0;
      for (int i = 0; i < N_EXT; i++) ana[i] = 10'h0A5 + 10'(i) * 10'h053;
      repeat (3) @(negedge CLK);
      RESET_N = 1'b1;
      prev = CODE_LO;
      for (int c = 0; c < 16; c++) begin
         host_xfer(4'(c), 5'(11 + c % 6), 1'b0, lvl(prev));
         prev = 4'(c);
      end
      host_xfer(4'h2, 5'd16, 1'b1, lvl(prev));
      host_xfer(4'h9, 5'd16, 1'b1, lvl(4'h2));
      host_xfer(4'h1, 5'd16, 1'b0, lvl(4'h9));
      host_xfer(4'h4, 5'd9, 1'b0, lvl(4'h1));
      for (int k = 0; k < 400 && ready !== 1'b1; k++) @(negedge CLK);
      check({6'h00, last_a}, {6'h00, lvl(4'h4)});
      check({15'h0000, busy_a}, 16'h0000);
      check({15'h0000, lb.dout_oe}, 16'h0000);
      b_xfer(CODE_MID, 16, got);
      check(got, 16'h0000);
      lb.cs_n = 1'b1;
      #1 check({15'h0000, lb.dout_oe}, 16'h0000);
      #300;
      repeat (3) begin
         lb.io_clk = 1'b1;
         lb.addr = 1'b1;
         #100 lb.io_clk = 1'b0;
         #100;
      end
      lb.addr = 1'b0;
      #1000 b_xfer(4'h3, 11, got);
      check(got, {lvl(CODE_MID), 6'h00});
      #100 lb.cs_n = 1'b1;
      #100 lb.cs_n = 1'b0;
      // Looked at after the abort lands but before the conversion could end on its own.
      #160 check({15'h0000, lb.eoc}, 16'h0001);
      check({15'h0000, busy_b}, 16'h0000);
      #1340;
      b_xfer(CODE_HI, 16, got);
      check(got, {lvl(CODE_MID), 6'h00});
      #1 check({15'h0000, lb.dout}, 16'h0001);
      b_xfer(4'h7, 16, got);
      check(got, {lvl(CODE_HI), 6'h00});
      #100 lb.cs_n = 1'b1;
      #1000 b_xfer(4'h0, 11, got);
      check(got, {lvl(4'h7), 6'h00});
      lb.cs_n = 1'b1;
      #1500 check({6'h00, last_b}, {6'h00, lvl(4'h0)});
      finish_test();
   end
endmodule // test_serial_adc_sequencer
